// ===== logic/line_fill_pkg.sv
// Purpose: Shared constants for the cache line fill link
// Assumes: 32-bit words, 4-word lines, single core clock
// Notes: Control bit values and line geometry
package line_fill_pkg;
    localparam int WORD_W = 32;
    localparam int LINE_WORDS = 4;
    localparam int OFS_W = 2;
    localparam logic FLAG_READ = 1'b0;
    localparam logic FLAG_WRITE = 1'b1;
    localparam logic FLAG_WIDE = 1'b0;
    localparam logic FLAG_BYTE = 1'b1;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam int FIFO_DEPTH = 16;
    localparam int REQ_W = 67;
endpackage

// ===== logic/cache_line_fill_link.sv
// Purpose: Cache miss and write-through link for both cache controllers
// Assumes: Link inputs come from logic on the same core clock
// Notes: Requests from the data cache side queue in a 16-entry FIFO
`timescale 1ns/100ps

module link_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk_i, // Core clock
    input wire logic rst_i, // Sync reset
    input wire logic in_valid_i, // Write side valid
    output logic in_ready_o, // Not full
    input wire logic [WIDTH-1:0] in_data_i, // Write data
    output logic out_valid_o, // Not empty
    input wire logic out_ready_i, // Drain side ready
    output logic [WIDTH-1:0] out_data_o // Head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_r;
    logic [AW:0] rd_r;
    wire do_wr = in_valid_i && in_ready_o;
    wire do_rd = out_valid_o && out_ready_i;
    assign in_ready_o = (wr_r - rd_r) != (AW+1)'(DEPTH);
    assign out_valid_o = wr_r != rd_r;
    assign out_data_o = mem_r[rd_r[AW-1:0]];
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (do_wr) wr_r <= wr_r + 1'b1;
            if (do_rd) rd_r <= rd_r + 1'b1;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (do_wr) mem_r[wr_r[AW-1:0]] <= in_data_i;
    end
endmodule // link_fifo

module cache_line_fill_link #(
    parameter bit iside_link_select = 1'b1,
    parameter bit dside_link_select = 1'b1
) (
    input wire logic sys_clk_i, // Core clock
    input wire logic rst_i, // Sync reset, active high
    // Instruction cache side
    input wire logic ireq_valid_i, // Read miss request
    output logic ireq_ready_o, // Request accepted
    input wire logic [line_fill_pkg::WORD_W-1:0] ireq_addr_i, // Miss addr
    output logic ifill_we_o, // Store word into cache
    output logic [line_fill_pkg::WORD_W-1:0] ifill_word_o, // Fill word
    output logic [line_fill_pkg::OFS_W-1:0] ifill_idx_o, // Word in line
    output logic icrit_valid_o, // Critical word to execution
    output logic [line_fill_pkg::WORD_W-1:0] icrit_word_o, // Crit word
    output logic ibusy_o, // Fill in progress
    // Data cache side
    input wire logic dreq_valid_i, // Read miss or store
    output logic dreq_ready_o, // Request accepted
    input wire logic dreq_write_i, // 1 store, 0 read miss
    input wire logic [1:0] dreq_size_i, // Byte, half, word
    input wire logic [line_fill_pkg::WORD_W-1:0] dreq_addr_i, // Address
    input wire logic [line_fill_pkg::WORD_W-1:0] dreq_wdata_i, // Store val
    output logic dfill_we_o, // Store word into cache
    output logic [line_fill_pkg::WORD_W-1:0] dfill_word_o, // Fill word
    output logic [line_fill_pkg::OFS_W-1:0] dfill_idx_o, // Word in line
    output logic dcrit_valid_o, // Load data to execution
    output logic [line_fill_pkg::WORD_W-1:0] dcrit_word_o, // Selected
    output logic dbusy_o, // Transfer in progress
    // Instruction links
    output logic iside_request_push_o, // Push strobe
    output logic [line_fill_pkg::WORD_W-1:0] iside_request_word_o, // Word
    output logic iside_request_flag_o, // Control bit
    input wire logic iside_request_stop_i, // Full
    output logic iside_request_clock_out_o, // Link clock
    output logic iside_return_pop_o, // Pop strobe
    input wire logic [line_fill_pkg::WORD_W-1:0] iside_return_word_i, // Word
    input wire logic iside_return_flag_i, // Control bit, unused
    input wire logic iside_return_present_i, // Word present
    output logic iside_return_clock_out_o, // Link clock
    // Data links
    output logic dside_request_push_o, // Push strobe
    output logic [line_fill_pkg::WORD_W-1:0] dside_request_word_o, // Word
    output logic dside_request_flag_o, // Control bit
    input wire logic dside_request_stop_i, // Full
    output logic dside_request_clock_out_o, // Link clock
    output logic dside_return_pop_o, // Pop strobe
    input wire logic [line_fill_pkg::WORD_W-1:0] dside_return_word_i, // Word
    input wire logic dside_return_flag_i, // Control bit
    input wire logic dside_return_present_i, // Word present
    output logic dside_return_clock_out_o // Link clock
);
    import line_fill_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10,
        ST_FILL = 2'b11
    } link_state_e;

    // Links run on the core clock itself
    assign iside_request_clock_out_o = sys_clk_i;
    assign iside_return_clock_out_o = sys_clk_i;
    assign dside_request_clock_out_o = sys_clk_i;
    assign dside_return_clock_out_o = sys_clk_i;

    // Instruction side
    link_state_e ist_r;
    link_state_e ist_nxt;
    logic [WORD_W-1:0] iaddr_r;
    logic [OFS_W-1:0] icnt_r;
    wire i_en = iside_link_select;
    wire i_take = i_en && ist_r == ST_IDLE && ireq_valid_i;
    wire i_push = ist_r == ST_ADDR && !iside_request_stop_i;
    wire i_pop = ist_r == ST_FILL && iside_return_present_i;
    wire i_last = i_pop && icnt_r == OFS_W'(LINE_WORDS - 1);
    assign ireq_ready_o = i_take;
    assign ibusy_o = ist_r != ST_IDLE;
    assign iside_request_push_o = i_push;
    assign iside_request_word_o = {iaddr_r[WORD_W-1:2], 2'h0};
    assign iside_request_flag_o = FLAG_READ;
    assign iside_return_pop_o = i_pop;

    always_comb begin
        ist_nxt = ist_r;
        case (ist_r)
            ST_IDLE: if (i_take) ist_nxt = ST_ADDR;
            ST_ADDR: if (i_push) ist_nxt = ST_FILL;
            ST_FILL: if (i_last) ist_nxt = ST_IDLE;
            default: ist_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ist_r <= ST_IDLE;
            iaddr_r <= '0;
            icnt_r <= '0;
        end else begin
            ist_r <= ist_nxt;
            if (i_take) iaddr_r <= ireq_addr_i;
            if (i_take) icnt_r <= '0;
            else if (i_pop) icnt_r <= icnt_r + 1'b1;
        end
    end

    // Fill index follows wrap order from the missed word
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ifill_we_o <= 1'b0;
            ifill_word_o <= '0;
            ifill_idx_o <= '0;
            icrit_valid_o <= 1'b0;
            icrit_word_o <= '0;
        end else begin
            ifill_we_o <= i_pop;
            icrit_valid_o <= i_pop && icnt_r == '0;
            if (i_pop) begin
                ifill_word_o <= iside_return_word_i;
                ifill_idx_o <= iaddr_r[3:2] + icnt_r;
            end
            if (i_pop && icnt_r == '0) icrit_word_o <= iside_return_word_i;
        end
    end

    // Data side requests are queued so the cache side sees back-pressure
    // Size sits above the write bit at 64
    localparam int SZ_LO = 65;
    wire [REQ_W-1:0] dq_in = {dreq_size_i, dreq_write_i, dreq_wdata_i[31:1],
        dreq_wdata_i[0], dreq_addr_i};
    wire [REQ_W-1:0] dq_out;
    wire dq_valid;
    logic dq_ready;
    logic dq_in_ready;
    assign dreq_ready_o = dq_in_ready && dside_link_select;

    link_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_dq (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .in_valid_i(dreq_valid_i && dside_link_select),
        .in_ready_o(dq_in_ready),
        .in_data_i(dq_in),
        .out_valid_o(dq_valid),
        .out_ready_i(dq_ready),
        .out_data_o(dq_out)
    );

    wire [WORD_W-1:0] hq_addr = dq_out[WORD_W-1:0];
    wire [WORD_W-1:0] hq_wdata = dq_out[2*WORD_W-1:WORD_W];
    wire hq_write = dq_out[2*WORD_W];
    wire [1:0] hq_size = dq_out[SZ_LO+1:SZ_LO];

    link_state_e dst_r;
    link_state_e dst_nxt;
    logic [WORD_W-1:0] daddr_r;
    logic [WORD_W-1:0] dwdata_r;
    logic [1:0] dsize_r;
    logic dwrite_r;
    logic [OFS_W-1:0] dcnt_r;
    wire d_take = dst_r == ST_IDLE && dq_valid;
    assign dq_ready = d_take;
    wire d_push = (dst_r == ST_ADDR || dst_r == ST_DATA)
        && !dside_request_stop_i;
    wire d_pop = dst_r == ST_FILL && dside_return_present_i;
    wire d_last = d_pop && dcnt_r == OFS_W'(LINE_WORDS - 1);
    assign dbusy_o = dst_r != ST_IDLE || dq_valid;

    // Lane replication for narrow stores
    wire [WORD_W-1:0] rep_byte = {4{dwdata_r[7:0]}};
    wire [WORD_W-1:0] rep_half = {2{dwdata_r[15:0]}};
    wire [WORD_W-1:0] wdata_lanes = dsize_r == SIZE_BYTE ? rep_byte :
        dsize_r == SIZE_HALF ? rep_half : dwdata_r;
    // Write address keeps low bits for lane encoding
    wire [WORD_W-1:0] rd_word = {daddr_r[WORD_W-1:2], 2'h0};
    wire in_addr = dst_r == ST_ADDR;
    assign dside_request_push_o = d_push;
    assign dside_request_word_o = !in_addr ? wdata_lanes :
        dwrite_r ? daddr_r : rd_word;
    assign dside_request_flag_o = in_addr ? (dwrite_r ? FLAG_WRITE :
        FLAG_READ) : (dsize_r == SIZE_BYTE ? FLAG_BYTE
        : FLAG_WIDE);
    assign dside_return_pop_o = d_pop;

    always_comb begin
        dst_nxt = dst_r;
        case (dst_r)
            ST_IDLE: if (d_take) dst_nxt = ST_ADDR;
            ST_ADDR: if (d_push) dst_nxt = dwrite_r ? ST_DATA : ST_FILL;
            ST_DATA: if (d_push) dst_nxt = ST_IDLE;
            ST_FILL: if (d_last) dst_nxt = ST_IDLE;
            default: dst_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            dst_r <= ST_IDLE;
            daddr_r <= '0;
            dwdata_r <= '0;
            dsize_r <= SIZE_WORD;
            dwrite_r <= 1'b0;
            dcnt_r <= '0;
        end else begin
            dst_r <= dst_nxt;
            if (d_take) begin
                daddr_r <= hq_addr;
                dwdata_r <= hq_wdata;
                dsize_r <= hq_size;
                dwrite_r <= hq_write;
            end
            if (d_take) dcnt_r <= '0;
            else if (d_pop) dcnt_r <= dcnt_r + 1'b1;
        end
    end

    // Load byte selection from the whole critical word
    wire [WORD_W-1:0] rw = dside_return_word_i;
    wire [1:0] bo = daddr_r[1:0];
    wire [7:0] sel_b = bo == 2'h0 ? rw[31:24] : bo == 2'h1 ? rw[23:16] :
        bo == 2'h2 ? rw[15:8] : rw[7:0];
    wire [15:0] sel_h = bo[1] ? rw[15:0] : rw[31:16];
    wire [WORD_W-1:0] load_val = dsize_r == SIZE_BYTE ? {24'h0, sel_b} :
        dsize_r == SIZE_HALF ? {16'h0, sel_h} : rw;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            dfill_we_o <= 1'b0;
            dfill_word_o <= '0;
            dfill_idx_o <= '0;
            dcrit_valid_o <= 1'b0;
            dcrit_word_o <= '0;
        end else begin
            dfill_we_o <= d_pop;
            dcrit_valid_o <= d_pop && dcnt_r == '0;
            if (d_pop) begin
                dfill_word_o <= rw;
                dfill_idx_o <= daddr_r[3:2] + dcnt_r;
            end
            if (d_pop && dcnt_r == '0) dcrit_word_o <= load_val;
        end
    end

    property p_i_push_ok;
        @(posedge sys_clk_i) disable iff (rst_i)
        iside_request_push_o |-> !iside_request_stop_i;
    endproperty
    a_i_push_ok: assert property (p_i_push_ok)
        else $error("i push while full");
    property p_d_push_ok;
        @(posedge sys_clk_i) disable iff (rst_i)
        dside_request_push_o |-> !dside_request_stop_i;
    endproperty
    a_d_push_ok: assert property (p_d_push_ok)
        else $error("d push while full");
    property p_d_pop_ok;
        @(posedge sys_clk_i) disable iff (rst_i)
        dside_return_pop_o |-> dside_return_present_i;
    endproperty
    a_d_pop_ok: assert property (p_d_pop_ok)
        else $error("d pop while empty");
    property p_i_read_flag;
        @(posedge sys_clk_i) disable iff (rst_i)
        iside_request_push_o |-> !iside_request_flag_o
            && iside_request_word_o[1:0] == 2'h0;
    endproperty
    a_i_read_flag: assert property (p_i_read_flag)
        else $error("bad i read request");
    property p_d_wr_pair;
        @(posedge sys_clk_i) disable iff (rst_i)
        (dside_request_push_o && dst_r == ST_ADDR && dwrite_r)
            |-> dside_request_flag_o ##1 (dst_r == ST_DATA);
    endproperty
    a_d_wr_pair: assert property (p_d_wr_pair)
        else $error("write address not followed by data");
    property p_d_byte_flag;
        @(posedge sys_clk_i) disable iff (rst_i)
        (dside_request_push_o && dst_r == ST_DATA)
            |-> dside_request_flag_o == (dsize_r == SIZE_BYTE);
    endproperty
    a_d_byte_flag: assert property (p_d_byte_flag)
        else $error("bad write data flag");
    property p_i_crit;
        @(posedge sys_clk_i) disable iff (rst_i)
        (i_pop && icnt_r == '0) |=> icrit_valid_o && ifill_we_o
            && icrit_word_o == ifill_word_o;
    endproperty
    a_i_crit: assert property (p_i_crit)
        else $error("critical word not forwarded");
    property p_i_four;
        @(posedge sys_clk_i) disable iff (rst_i)
        (ist_r == ST_FILL && $past(ist_r) == ST_ADDR)
            |-> !iside_return_pop_o || icnt_r == '0;
    endproperty
    a_i_four: assert property (p_i_four)
        else $error("fill count not restarted");
endmodule // cache_line_fill_link

// ===== verification/mem_link_model.sv
// Purpose: Memory controller model for one cache side's link pair
// Assumes: Same core clock as the design
// Notes: Each returned word equals its own byte address
`timescale 1ns/100ps

module mem_link_model (
    input wire logic sys_clk_i, // Core clock
    input wire logic rst_i, // Sync reset
    input wire logic [1:0] mode_i, // 0 prompt, 1 random stalls, 2 full
    input wire logic push_i, // Request push strobe
    input wire logic [31:0] word_i, // Request word
    input wire logic flag_i, // Request control bit
    input wire logic pop_i, // Return pop strobe
    output logic stop_o, // Request full
    output logic present_o, // Return word present
    output logic [31:0] rword_o, // Return word
    output logic rflag_o // Return control bit, junk
);
    logic [31:0] rq[$];
    bit data_next;

    always @(posedge sys_clk_i) begin
        bit go;
        go = (mode_i == 2'h0) || ($urandom_range(1) == 1);
        if (rst_i) begin
            rq.delete();
            data_next = 0;
        end else begin
            if (push_i && !stop_o) begin
                if (data_next)
                    data_next = 0;
                else if (flag_i)
                    data_next = 1;
                else
                    for (int n = 0; n < 4; n++)
                        rq.push_back({word_i[31:4], 2'(word_i[3:2] + n),
                            2'h0});
            end
            if (pop_i && present_o)
                void'(rq.pop_front());
        end
        stop_o <= !rst_i && (mode_i == 2'h2 || (mode_i != 0 && !go));
        present_o <= go && rq.size() > 0;
        // Released bus shows no stale word
        rword_o <= (go && rq.size() > 0) ? rq[0] :
            (rst_i ? 32'h0 : ~rword_o);
        rflag_o <= !rst_i && !rflag_o;
    end
endmodule // mem_link_model

// ===== verification/cache_line_fill_link_bench.sv
// Purpose: Self-checking bench for the cache line fill link
// Assumes: One model per cache side, return words equal their address
// Notes: One side active at a time, so one event log serves both
`timescale 1ns/100ps

module cache_line_fill_link_bench;
    import line_fill_pkg::*;
    logic sys_clk, rst, iv, dv, dw, ok;
    logic [1:0] dsz, mi, md, s;
    logic [31:0] ia, da, dd, a;
    logic ir, ifw, icv, ib, dr, dfw, dcv, db;
    logic ip, iflg, ipop, dp, dflg, dpop, ist, ipr, dst, dpr, irf, drf;
    logic [1:0] ifi, dfi;
    logic [3:0] lck;
    logic [31:0] ifwd, icwd, dfwd, dcwd, iqw, dqw, irw, drw;
    logic [32:0] rq[$], xr[$];
    logic [33:0] fq[$], xf[$];
    logic [31:0] cq[$], xc[$];
    int bad_count, n_tests, k;

    cache_line_fill_link cache_line_fill_link_i (.sys_clk_i(sys_clk),
        .rst_i(rst), .ireq_valid_i(iv), .ireq_ready_o(ir), .ireq_addr_i(ia),
        .ifill_we_o(ifw), .ifill_word_o(ifwd), .ifill_idx_o(ifi),
        .icrit_valid_o(icv), .icrit_word_o(icwd), .ibusy_o(ib),
        .dreq_valid_i(dv), .dreq_ready_o(dr), .dreq_write_i(dw),
        .dreq_size_i(dsz), .dreq_addr_i(da), .dreq_wdata_i(dd),
        .dfill_we_o(dfw), .dfill_word_o(dfwd), .dfill_idx_o(dfi),
        .dcrit_valid_o(dcv), .dcrit_word_o(dcwd), .dbusy_o(db),
        .iside_request_push_o(ip), .iside_request_word_o(iqw),
        .iside_request_flag_o(iflg), .iside_request_stop_i(ist),
        .iside_request_clock_out_o(lck[0]), .iside_return_pop_o(ipop),
        .iside_return_word_i(irw), .iside_return_flag_i(irf),
        .iside_return_present_i(ipr), .iside_return_clock_out_o(lck[1]),
        .dside_request_push_o(dp), .dside_request_word_o(dqw),
        .dside_request_flag_o(dflg), .dside_request_stop_i(dst),
        .dside_request_clock_out_o(lck[2]), .dside_return_pop_o(dpop),
        .dside_return_word_i(drw), .dside_return_flag_i(drf),
        .dside_return_present_i(dpr), .dside_return_clock_out_o(lck[3]));
    mem_link_model iside_model_i (.sys_clk_i(sys_clk), .rst_i(rst),
        .mode_i(mi), .push_i(ip), .word_i(iqw), .flag_i(iflg),
        .pop_i(ipop), .stop_o(ist), .present_o(ipr), .rword_o(irw),
        .rflag_o(irf));
    mem_link_model dside_model_i (.sys_clk_i(sys_clk), .rst_i(rst),
        .mode_i(md), .push_i(dp), .word_i(dqw), .flag_i(dflg),
        .pop_i(dpop), .stop_o(dst), .present_o(dpr), .rword_o(drw),
        .rflag_o(drf));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(string what, logic [35:0] e, logic [35:0] g);
        n_tests++;
        if (e !== g) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        if ((ip && ist) || (dp && dst) || (ipop && !ipr) || (dpop && !dpr))
            chk("strobe gating", 0, 1);
        if ((icv && !ifw) || (dcv && !dfw))
            chk("crit with store", 0, 1);
        if (ip) rq.push_back({iflg, iqw});
        if (dp) rq.push_back({dflg, dqw});
        if (ifw) fq.push_back({ifi, ifwd});
        if (dfw) fq.push_back({dfi, dfwd});
        if (icv) cq.push_back(icwd);
        if (dcv) cq.push_back(dcwd);
    end

    function automatic logic [31:0] sel(logic [31:0] w, logic [1:0] o,
        logic [1:0] sz);
        if (sz == SIZE_BYTE) return {24'h0, w[31-8*o -: 8]};
        if (sz == SIZE_HALF) return {16'h0, w[31-8*o -: 16]};
        return w;
    endfunction

    // Waits for acceptance; lowers valid at the accepting edge
    task automatic take(bit d, int lim, output logic got);
        got = 0;
        for (int t = 0; t < lim && !got; t++) begin
            @(negedge sys_clk);
            got = d ? dr === 1'b1 : ir === 1'b1;
        end
        @(posedge sys_clk);
        iv <= 1'b0;
        dv <= 1'b0;
    endtask

    task automatic rd(bit d, logic [31:0] ad, logic [1:0] sz);
        logic [31:0] w;
        @(posedge sys_clk);
        iv <= !d;
        dv <= d;
        dw <= 1'b0;
        ia <= ad;
        da <= ad;
        dsz <= sz;
        take(d, 300, ok);
        w = {ad[31:2], 2'h0};
        xr.push_back({FLAG_READ, w});
        for (int n = 0; n < LINE_WORDS; n++)
            xf.push_back({2'(ad[3:2] + n), ad[31:4], 2'(ad[3:2] + n), 2'h0});
        xc.push_back(d ? sel(w, ad[1:0], sz) : w);
    endtask

    task automatic st(logic [31:0] ad, logic [31:0] v, logic [1:0] sz,
        int lim);
        @(posedge sys_clk);
        dv <= 1'b1;
        dw <= 1'b1;
        da <= ad;
        dd <= v;
        dsz <= sz;
        take(1, lim, ok);
        if (ok) begin
            xr.push_back({FLAG_WRITE, ad});
            xr.push_back({sz == SIZE_BYTE, sz == SIZE_BYTE ? {4{v[7:0]}} :
                sz == SIZE_HALF ? {2{v[15:0]}} : v});
        end
    endtask

    // Busy flags only rise after the accepting edge has settled
    task automatic drain(string name);
        @(negedge sys_clk);
        for (int t = 0; t < 600 && (ib !== 1'b0 || db !== 1'b0); t++)
            @(negedge sys_clk);
        repeat (2) @(negedge sys_clk);
        chk({name, " idle"}, 0, {ib, db});
        #1;
        chk({name, " clocks"}, 0, lck);
        chk({name, " words"}, xr.size(), rq.size());
        chk({name, " fills"}, xf.size(), fq.size());
        chk({name, " crits"}, xc.size(), cq.size());
        while (xr.size() > 0 && rq.size() > 0)
            chk({name, " req"}, xr.pop_front(), rq.pop_front());
        while (xf.size() > 0 && fq.size() > 0)
            chk({name, " fill"}, xf.pop_front(), fq.pop_front());
        while (xc.size() > 0 && cq.size() > 0)
            chk({name, " crit"}, xc.pop_front(), cq.pop_front());
        xr.delete();
        rq.delete();
        xf.delete();
        fq.delete();
        xc.delete();
        cq.delete();
        $display("test %s done", name);
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        $display("FAIL watchdog expected finish seen hang");
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        {iv, dv, dw, dsz, mi, md, ia, da, dd} = '0;
        void'($urandom(32'h24029563));
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rd(0, 32'h34b, SIZE_WORD);
        drain("iside wrap");
        for (k = 0; k < 4; k++)
            rd(1, 32'h2c0 + k, SIZE_BYTE);
        rd(1, 32'h2ce, SIZE_HALF);
        drain("dside lanes");
        for (k = 0; k < 3; k++)
            st(32'h47 - k - (k > 1), 32'h9abc_de5a + k, 2'(k), 300);
        drain("store sizes");
        md <= 2'h2;
        k = 0;
        do begin
            st($urandom & 32'hffff_fffc, $urandom, SIZE_WORD, 3);
            k += ok;
        end while (ok && k < 30);
        chk("fifo depth", 1, k >= FIFO_DEPTH && k <= FIFO_DEPTH + 2);
        md <= 2'h1;
        drain("fifo fill");
        for (int r = 0; r < 40; r++) begin
            mi <= 2'($urandom_range(1));
            md <= 2'($urandom_range(1));
            s = 2'($urandom_range(2));
            a = $urandom & ~(s == SIZE_WORD ? 32'h3 : {31'h0, s[0]});
            case ($urandom_range(2))
                0: rd(0, a, SIZE_WORD);
                1: rd(1, a, s);
                default: st(a, $urandom, s, 300);
            endcase
            drain("random");
        end
        wrap_up();
    end
endmodule // cache_line_fill_link_bench
